// [src/emc_pkg.sv]
// Constants, carriers and state layout of the embedded memory block.
// Assumes a single 40 MHz clock; all slower port clocks arrive as enable pulses.
package emc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned DATA_W    = 16;   // RAM port width
  localparam int unsigned RAM_AW    = 8;
  localparam int unsigned RAM_WORDS = 256;
  localparam int unsigned CAM_WORDS = 32;
  localparam int unsigned CAM_W     = 32;
  localparam int unsigned LINES     = 16;   // Match lines per cycle
  localparam int unsigned CAM_AW    = 5;
  localparam int unsigned SEL_BIT   = 31;   // Bank select bit of the key

  ////////////////////////////////////////////////////////////////////////////
  // Software registers (byte addresses)
  localparam logic [3:0]  REG_CFG  = 4'h0;
  localparam logic [3:0]  REG_STAT = 4'h4;
  localparam int unsigned CFG_MODE_LSB  = 0;
  localparam int unsigned CFG_CMODE_LSB = 2;
  localparam int unsigned CFG_ENC_BIT   = 4;
  localparam int unsigned CFG_BYP_LSB   = 5;
  localparam logic [31:0] CFG_MASK = 32'h0000_07ff;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam int unsigned ST_FLAG_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 1;
  localparam int unsigned ST_ENC_LSB  = 8;

  // Bypass bit positions inside the bypass field
  localparam int unsigned BYP_WDATA = 0;
  localparam int unsigned BYP_RDATA = 1;
  localparam int unsigned BYP_RADDR = 2;
  localparam int unsigned BYP_WADDR = 3;
  localparam int unsigned BYP_WR    = 4;
  localparam int unsigned BYP_RD    = 5;

  // Compare masks
  localparam logic [31:0] KEY_MASK_ENC   = 32'hffff_ffff;
  localparam logic [31:0] KEY_MASK_UNENC = 32'h7fff_ffff;
  localparam logic [31:0] FAST_MASK      = 32'h0000_ffff;

  ////////////////////////////////////////////////////////////////////////////
  // Modes and states
  typedef enum logic [1:0] {EMC_DUAL, EMC_SINGLE, EMC_CAM, EMC_ROM} emc_mode_t;
  typedef enum logic [1:0] {EMC_CM_SINGLE, EMC_CM_MULTI, EMC_CM_FAST} emc_cmode_t;
  typedef enum logic [1:0] {EMC_W_IDLE, EMC_W_VAL, EMC_W_CARE} emc_wst_t;

  typedef logic [CAM_WORDS-1:0][CAM_W-1:0] emc_words_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic              in_tick;   // Edge of the input-side clock
    logic              out_tick;  // Edge of the output-side clock
    logic              wce;       // Write clock enable
    logic              rce;       // Read clock enable
    logic              clr;       // Port clear
    logic              wr;
    logic              read_strobe;
    logic [RAM_AW-1:0] waddr;
    logic [RAM_AW-1:0] raddr;
    logic [DATA_W-1:0] wdata;
  } emc_port_in_t;

  typedef struct packed {
    logic [CAM_W-1:0]  key;
    logic [CAM_AW-1:0] addr;
    logic [CAM_W-1:0]  care;      // 1 = bit takes part in compare
    logic              wr;
    logic              wr_care;   // Write carries don't-care bits
    logic              look;
  } emc_cam_in_t;

  typedef struct packed {
    logic              valid;
    logic              phase;     // 0 first result cycle, 1 odd-bank second cycle of a multiple match
    logic              flag;
    logic [CAM_AW-1:0] enc;
    logic [LINES-1:0]  lines;
  } emc_cam_out_t;

  typedef struct packed {
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] wdata;
    logic [RAM_AW-1:0] waddr;
    logic [RAM_AW-1:0] raddr;
    logic              wr;
    logic              rd;
  } emc_preg_t;

  typedef struct packed {
    logic [RAM_WORDS-1:0][DATA_W-1:0] ram;
    emc_words_t                       val;
    emc_words_t                       care;
    logic [31:0]                      cfg;
    emc_preg_t [1:0]                  prt;
    emc_wst_t                         wst;
    logic [CAM_AW-1:0]                waddr;
    logic [CAM_W-1:0]                 wval;
    logic [CAM_W-1:0]                 wcare;
    logic                             wcare_en;
    logic                             lk_act;
    logic [CAM_W-1:0]                 key;
    emc_cam_out_t                     cout;
    logic [31:0]                      rdata;
  } emc_state_t;

endpackage

// [src/emc_block.sv]
// Embedded memory block: dual/single-port RAM, ROM lookup and a 32x32 CAM.
// Assumes user logic drives port and CAM strobes synchronous to clk and
// waits for cam_ready before a CAM request.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps

// Notes on behaviour
// [RL1] Each port: input registers on input tick, output register on output tick.
// [RL2] Each port has own read enable, write enable and clear.
// [RL3] All registers clear from port clear, global clear or chip reset.
// [RL4] Single-port mode splits the RAM into two independent halves.
// [RL5] CAM compares key with all entries at once, reports address and flag.
// [RL6] One CAM holds 32 entries of 32 bits.
// [RL7] Don't-care bits are excluded from the compare.
// [RL8] Single, multiple and fast multiple match modes, encoded or unencoded.
// [RL9] Encoded output is the binary index of the matching entry.
// [RL10] Unencoded output is 16 lines; 32 entries span two banks.
// [RL11] Unencoded lookups compare 31 bits; the top key bit picks the bank.
// [RL12] Select 1 shows odd entries, select 0 shows even entries.
// [RL13] Single match: two-cycle write, one-cycle lookup, both outputs.
// [RL14] Multiple match: two cycles of 16 lines cover all 32 entries.
// [RL15] User logic priority-encodes multiple-match lines when it wants one address.
// [RL16] Fast multiple match: one cycle, only entries 0 to 15 searched.
// [RL17] Contents preloaded at reset; writes take two cycles, three with masks.
// [RL18] Each port path register can be bypassed independently; here both ports share one bypass field.
// [RL19] ROM mode serves a pattern loaded at reset, writes refused.
// [RL20] Flag is low on a lookup with no masked match.
module emc_block #(
  parameter logic [4095:0] RAM_INIT  = '0,
  parameter logic [1023:0] CAM_VINIT = '0,
  parameter logic [1023:0] CAM_CINIT = '1
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   glb_clr,
  input  wire logic [3:0]             sw_addr,
  input  wire logic [31:0]            sw_wdata,
  input  wire logic                   sw_wr,
  input  wire logic                   sw_rd,
  output      logic [31:0]            sw_rdata,
  input  wire emc_pkg::emc_port_in_t  port_a,
  input  wire emc_pkg::emc_port_in_t  port_b,
  output      logic [15:0]            a_dout,
  output      logic [15:0]            b_dout,
  input  wire emc_pkg::emc_cam_in_t   cam_in,
  output      logic                   cam_ready,
  output      emc_pkg::emc_cam_out_t  cam_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Match helpers

  // Hit per entry; masked bits of entry or key never block a hit
  function automatic logic [31:0] cam_hits(input logic [31:0] key,
                                           input logic [31:0] kmask,
                                           input emc_pkg::emc_words_t v,
                                           input emc_pkg::emc_words_t c);
    logic [31:0] h;
    h = '0;
    for (int e = 0; e < emc_pkg::CAM_WORDS; e++) begin
      h[e] = (((v[e] ^ key) & c[e] & kmask) == '0); // see [RL5] [RL7]
    end
    return h;
  endfunction

  // Entry 2i+sel drives line i
  function automatic logic [15:0] bank(input logic [31:0] h, input logic sel);
    logic [15:0] l;
    l = '0;
    for (int i = 0; i < emc_pkg::LINES; i++) begin
      l[i] = h[2*i + int'(sel)]; // see [RL10] [RL12]
    end
    return l;
  endfunction

  // Lowest matching index wins
  function automatic logic [4:0] first_hit(input logic [31:0] h);
    logic [4:0] a;
    a = '0;
    for (int e = emc_pkg::CAM_WORDS - 1; e >= 0; e--) begin
      if (h[e]) begin
        a = 5'(e); // see [RL9]
      end
    end
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  emc_pkg::emc_state_t          s_q;
  emc_pkg::emc_state_t          s_d;
  emc_pkg::emc_port_in_t [1:0]  p_in;
  emc_pkg::emc_mode_t           mode;
  emc_pkg::emc_cmode_t          cmode;
  logic                         enc_sel;
  logic [5:0]                   byp;
  logic [31:0]                  kmask;
  logic                         idle;

  assign p_in    = {port_b, port_a};
  assign mode    = emc_pkg::emc_mode_t'(s_q.cfg[emc_pkg::CFG_MODE_LSB +: 2]);
  assign cmode   = emc_pkg::emc_cmode_t'(s_q.cfg[emc_pkg::CFG_CMODE_LSB +: 2]);
  assign enc_sel = s_q.cfg[emc_pkg::CFG_ENC_BIT];
  assign byp     = s_q.cfg[emc_pkg::CFG_BYP_LSB +: 6];

  // Unencoded lookups give up the top key bit to the bank select
  assign kmask = enc_sel ? emc_pkg::KEY_MASK_ENC : emc_pkg::KEY_MASK_UNENC; // see [RL11]

  // Lookups and writes are refused while a write or second phase runs
  assign idle = (s_q.wst == emc_pkg::EMC_W_IDLE) && !s_q.lk_act;
  assign cam_ready = idle && (mode == emc_pkg::EMC_CAM); // see [RL17]

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [emc_pkg::DATA_W-1:0] wd;
    logic [7:0]                 wa;
    logic [7:0]                 ra;
    logic                       we;
    logic                       rd_en;
    logic                       clr;
    logic                       ram_md;
    logic [31:0]                h;
    logic [31:0]                key_use;
    wd      = '0;
    wa      = '0;
    ra      = '0;
    we      = 1'b0;
    rd_en   = 1'b0;
    clr     = 1'b0;
    ram_md  = 1'b0;
    h       = '0;
    key_use = '0;
    s_d     = s_q;

    // Port B first so a same-cycle write from port A lands last
    for (int i = 1; i >= 0; i--) begin
      clr = p_in[i].clr | glb_clr; // see [RL2] [RL3]
      // Each path takes the live input when bypassed, else its register
      wd = byp[emc_pkg::BYP_WDATA] ? p_in[i].wdata : s_q.prt[i].wdata; // see [RL18]
      wa = byp[emc_pkg::BYP_WADDR] ? p_in[i].waddr : s_q.prt[i].waddr;
      ra = byp[emc_pkg::BYP_RADDR] ? p_in[i].raddr : s_q.prt[i].raddr;
      we = byp[emc_pkg::BYP_WR] ? p_in[i].wr : s_q.prt[i].wr;
      rd_en = byp[emc_pkg::BYP_RD] ? p_in[i].read_strobe : s_q.prt[i].rd;
      if (mode == emc_pkg::EMC_SINGLE) begin
        // One address per port, upper bit fixed to the port's half
        wa = {1'(i), wa[6:0]}; // see [RL4]
        ra = wa;
        rd_en = rd_en & !we;
      end
      ram_md = (mode == emc_pkg::EMC_DUAL) || (mode == emc_pkg::EMC_SINGLE);
      if (p_in[i].in_tick && p_in[i].wce && we && ram_md && !clr) begin
        s_d.ram[wa] = wd; // see [RL1] [RL19]
      end
      // Output register; bypass makes it follow every cycle
      if (clr) begin
        s_d.prt[i].dout = '0;
      end else if ((p_in[i].out_tick || byp[emc_pkg::BYP_RDATA]) && p_in[i].rce && rd_en &&
                   (mode != emc_pkg::EMC_CAM)) begin
        s_d.prt[i].dout = s_q.ram[ra]; // see [RL1] [RL19]
      end
      // Input registers on the input-side tick
      if (clr) begin
        s_d.prt[i].wdata = '0;
        s_d.prt[i].waddr = '0;
        s_d.prt[i].raddr = '0;
        s_d.prt[i].wr    = 1'b0;
        s_d.prt[i].rd    = 1'b0;
      end else if (p_in[i].in_tick) begin
        if (p_in[i].wce) begin
          s_d.prt[i].wdata = p_in[i].wdata; // see [RL1] [RL2]
          s_d.prt[i].waddr = p_in[i].waddr;
          s_d.prt[i].wr    = p_in[i].wr;
        end
        if (p_in[i].rce) begin
          s_d.prt[i].raddr = p_in[i].raddr;
          s_d.prt[i].rd    = p_in[i].read_strobe;
        end
      end
    end

    // CAM write sequence: request, value cycle, optional care cycle
    unique case (s_q.wst)
      emc_pkg::EMC_W_IDLE: begin
        if (cam_ready && cam_in.wr) begin
          s_d.wst      = emc_pkg::EMC_W_VAL;
          s_d.waddr    = cam_in.addr;
          s_d.wval     = cam_in.key;
          s_d.wcare    = cam_in.care;
          s_d.wcare_en = cam_in.wr_care;
        end
      end
      emc_pkg::EMC_W_VAL: begin
        s_d.val[s_q.waddr]  = s_q.wval; // see [RL13] [RL17]
        s_d.care[s_q.waddr] = '1;
        s_d.wst = s_q.wcare_en ? emc_pkg::EMC_W_CARE : emc_pkg::EMC_W_IDLE;
      end
      emc_pkg::EMC_W_CARE: begin
        s_d.care[s_q.waddr] = s_q.wcare; // see [RL7] [RL17]
        s_d.wst = emc_pkg::EMC_W_IDLE;
      end
      default: begin
        s_d.wst = emc_pkg::EMC_W_IDLE;
      end
    endcase

    // CAM lookup; a write request in the same cycle takes priority
    key_use = s_q.lk_act ? s_q.key : cam_in.key;
    h = cam_hits(key_use, kmask, s_q.val, s_q.care); // see [RL5] [RL6]
    if (cmode == emc_pkg::EMC_CM_FAST) begin
      h = h & emc_pkg::FAST_MASK; // see [RL16]
    end
    s_d.cout.valid = 1'b0;
    if (s_q.lk_act) begin
      // Second cycle of a multiple-match lookup shows the odd bank
      s_d.lk_act      = 1'b0;
      s_d.cout.valid  = 1'b1;
      s_d.cout.phase  = 1'b1;
      s_d.cout.lines  = bank(h, 1'b1); // see [RL14]
      s_d.cout.flag   = |h;
    end else if (cam_ready && cam_in.look && !cam_in.wr) begin
      s_d.cout.valid = 1'b1;
      s_d.cout.phase = 1'b0;
      s_d.cout.flag  = |h; // see [RL5] [RL20]
      s_d.cout.enc   = first_hit(h); // see [RL9] [RL15]
      unique case (cmode)
        emc_pkg::EMC_CM_MULTI: begin
          s_d.lk_act     = 1'b1;
          s_d.key        = cam_in.key;
          s_d.cout.lines = bank(h, 1'b0); // see [RL8] [RL14]
        end
        emc_pkg::EMC_CM_FAST: begin
          s_d.cout.lines = h[15:0]; // see [RL16]
        end
        default: begin
          s_d.cout.lines = bank(h, cam_in.key[emc_pkg::SEL_BIT]); // see [RL13] [RL11]
        end
      endcase
    end
    if (glb_clr) begin
      s_d.cout   = '0; // see [RL3]
      s_d.lk_act = 1'b0;
      s_d.wst    = emc_pkg::EMC_W_IDLE;
    end

    // Software register port
    if (sw_wr && (sw_addr == emc_pkg::REG_CFG)) begin
      s_d.cfg = sw_wdata & emc_pkg::CFG_MASK;
    end
    s_d.rdata = '0;
    if (sw_rd) begin
      unique case (sw_addr)
        emc_pkg::REG_CFG:  s_d.rdata = s_q.cfg;
        emc_pkg::REG_STAT: begin
          s_d.rdata[emc_pkg::ST_FLAG_BIT]         = s_q.cout.flag;
          s_d.rdata[emc_pkg::ST_BUSY_BIT]         = !idle;
          s_d.rdata[emc_pkg::ST_ENC_LSB +: 5]     = s_q.cout.enc;
        end
        default:           s_d.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register stage; reset stands in for configuration load

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q      <= '0;
      s_q.ram  <= RAM_INIT; // see [RL17] [RL19]
      s_q.val  <= CAM_VINIT;
      s_q.care <= CAM_CINIT;
      s_q.cfg  <= emc_pkg::CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sw_rdata = s_q.rdata;
  assign a_dout   = s_q.prt[0].dout;
  assign b_dout   = s_q.prt[1].dout;
  assign cam_out  = s_q.cout;

endmodule

// [test/emc_block_asserts.sv]
// Checker for the embedded memory block, seeing the top ports only.
// Assumes one clock; srst and glb_clr both clear the CAM result logic.
`timescale 1ns/100ps
module emc_block_asserts (
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic                  glb_clr,
  input wire logic                  sw_wr,
  input wire logic                  sw_rd,
  input wire logic [31:0]           sw_rdata,
  input wire emc_pkg::emc_port_in_t port_a,
  input wire emc_pkg::emc_port_in_t port_b,
  input wire logic [15:0]           a_dout,
  input wire logic [15:0]           b_dout,
  input wire emc_pkg::emc_cam_in_t  cam_in,
  input wire logic                  cam_ready,
  input wire emc_pkg::emc_cam_out_t cam_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst || glb_clr);

  ////////////////////////////////////////////////////////////
  // Write sequencing: request, busy cycles, ready again
  sequence wr_req_s;
    cam_ready && cam_in.wr;
  endsequence
  sequence plain_busy_s;
    !cam_ready ##1 cam_ready;
  endsequence
  sequence care_busy_s;
    !cam_ready [*2] ##1 cam_ready;
  endsequence

  write_plain_a: assert property (wr_req_s ##0 !cam_in.wr_care |=> plain_busy_s)
    else $error("plain CAM write busy time wrong");
  write_care_a: assert property (wr_req_s ##0 cam_in.wr_care |=> care_busy_s)
    else $error("masked CAM write busy time wrong");
  lookup_answer_a: assert property (cam_ready && cam_in.look && !cam_in.wr |=> cam_out.valid)
    else $error("lookup gave no result next cycle");
  line_flag_a: assert property (cam_out.valid && cam_out.lines != '0 |-> cam_out.flag)
    else $error("match line high with flag low");
  // Result fields hold between valid pulses; valid itself falls after each pulse
  result_hold_a: assert property (!cam_out.valid && !$past(glb_clr) |->
      $stable({cam_out.phase, cam_out.flag, cam_out.enc, cam_out.lines}))
    else $error("CAM result moved without valid");
  ready_fall_a: assert property ($fell(cam_ready) |->
      $past(cam_in.wr) || $past(cam_in.look) || $past(sw_wr))
    else $error("CAM ready dropped without a request");
  rdata_idle_a: assert property (!$past(sw_rd) |-> sw_rdata == '0)
    else $error("read data outside its cycle");
  a_dout_cause_a: assert property ($changed(a_dout) |->
      $past(port_a.rce) || $past(port_a.clr) || $past(glb_clr))
    else $error("port A output moved without read enable");
  b_dout_cause_a: assert property ($changed(b_dout) |->
      $past(port_b.rce) || $past(port_b.clr) || $past(glb_clr))
    else $error("port B output moved without read enable");
endmodule

bind emc_block emc_block_asserts u_chk (.clk, .srst, .glb_clr, .sw_wr, .sw_rd, .sw_rdata,
  .port_a, .port_b, .a_dout, .b_dout, .cam_in, .cam_ready, .cam_out);

// [test/emc_prio_model.sv]
// Fabric-side priority encoder folding the two multiple-match banks.
// Assumes arm is high only while the CAM runs multiple-match unencoded.
`timescale 1ns/100ps
module emc_prio_model (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  arm,
  input  wire emc_pkg::emc_cam_out_t cam_out,
  output      logic                  done,
  output      logic [5:0]            pick
);
  logic [5:0] nb;

  // Lowest hit index so far; 6'h3f stands for no hit at all
  always_comb begin
    nb = cam_out.phase ? pick : 6'h3f;
    for (int i = 15; i >= 0; i--) begin
      if (cam_out.lines[i] && 6'(2 * i + int'(cam_out.phase)) < nb) begin
        nb = 6'(2 * i + int'(cam_out.phase));
      end
    end
  end

  // Even bank starts the search, odd bank finishes it and raises done
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (srst) begin
      pick <= 6'h3f;
    end else if (cam_out.valid && arm) begin
      pick <= nb;
      done <= cam_out.phase;
    end
  end
endmodule

// [test/tb_emc_block.sv]
// Self-checking bench for the memory block: CAM modes, RAM ports, registers.
// Assumes the checker is bound from its own file; expectations go via queues.
`timescale 1ns/100ps
module tb_emc_block;
  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  logic                  glb_clr = 1'b0;
  logic [3:0]            sw_addr = '0;
  logic [31:0]           sw_wdata = '0;
  logic                  sw_wr = 1'b0;
  logic                  sw_rd = 1'b0;
  logic [31:0]           sw_rdata;
  emc_pkg::emc_port_in_t port_a = '0;
  emc_pkg::emc_port_in_t port_b = '0;
  logic [15:0]           a_dout;
  logic [15:0]           b_dout;
  emc_pkg::emc_cam_in_t  cam_in = '0;
  logic                  cam_ready;
  emc_pkg::emc_cam_out_t cam_out;
  logic                  arm = 1'b0;
  logic                  done;
  logic [5:0]            pick;
  logic                  rd_d = 1'b0;
  logic [43:0]           ce;
  logic [31:0]           k;
  logic [31:0]           tv[32];
  logic [31:0]           tc[32];
  logic [31:0]           reg_q[$];
  logic [43:0]           cam_q[$];
  logic [5:0]            pick_q[$];
  int                    failures = 0;
  int                    checked = 0;
  int                    cycles = 0;

  emc_block dut (.clk, .srst, .glb_clr, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata,
    .port_a, .port_b, .a_dout, .b_dout, .cam_in, .cam_ready, .cam_out);
  emc_prio_model u_user (.clk, .srst, .arm, .cam_out, .done, .pick);

  initial begin
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Register strobes keep a gap cycle so no strobe is set twice in one step
  task automatic sw_w(input logic [3:0] a, input logic [31:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic sw_r(input logic [3:0] a, input logic [31:0] e);
    reg_q.push_back(e);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(posedge clk);
  endtask

  // CAM request held until an edge samples ready high; mirrors writes
  task automatic cam_req(input logic w, input logic wc, input logic [4:0] a,
                         input logic [31:0] key, input logic [31:0] c);
    int n;
    n = 0;
    cam_in <= '{key: key, addr: a, care: c, wr: w, wr_care: wc, look: !w};
    do begin
      @(posedge clk);
      n++;
    end while (cam_ready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    cam_in.wr <= 1'b0;
    cam_in.look <= 1'b0;
    @(posedge clk);
    if (w) begin
      tv[a] = key;
      tc[a] = wc ? c : '1;
    end
  endtask

  // Lookup with expectations worked out from the mirror of the contents
  task automatic look(input logic [31:0] key, input int cm, input logic en);
    logic [31:0] hit;
    logic [15:0] ln;
    logic [4:0]  lo;
    logic [21:0] mk;
    hit = '0;
    lo = '0;
    for (int i = 31; i >= 0; i--) begin
      if (((tv[i] ^ key) & tc[i] & {en, 31'h7fff_ffff}) == '0 && (cm != 2 || i < 16)) begin
        hit[i] = 1'b1;
        lo = 5'(i);
      end
    end
    mk = {1'b1, {5{|hit}}, {16{!en}}};
    for (int p = 0; p <= int'(cm == 1); p++) begin
      for (int j = 0; j < 16; j++) begin
        ln[j] = (cm == 2) ? hit[j] : hit[2 * j + ((cm == 1) ? p : int'(key[31]))];
      end
      cam_q.push_back({mk, |hit, lo, ln});
    end
    if (cm == 1 && !en) pick_q.push_back(|hit ? {1'b0, lo} : 6'h3f);
    cam_req(1'b0, 1'b0, 5'h00, key, '0);
  endtask

  // Port A writes, then both ports read back at the falling edge after dout lands;
  // waddr rides along because single-port mode addresses reads with it
  task automatic ram(input logic c, input logic [7:0] a, input logic [15:0] d,
                     input logic [15:0] e, input logic [15:0] ea);
    port_a <= '{in_tick: 1'b1, wce: 1'b1, wr: 1'b1, clr: c, waddr: a, wdata: d, default: '0};
    @(posedge clk);
    port_a <= '{in_tick: 1'b1, out_tick: 1'b1, rce: 1'b1, read_strobe: 1'b1, raddr: a,
                waddr: a, default: '0};
    port_b <= '{in_tick: 1'b1, out_tick: 1'b1, rce: 1'b1, read_strobe: 1'b1, raddr: a,
                waddr: a, default: '0};
    @(posedge clk);
    port_a <= '0;
    port_b <= '0;
    @(negedge clk);
    chk(32'(b_dout), 32'(e));
    chk(32'(a_dout), 32'(ea));
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////
  // Result watcher: oldest note against each answer
  always @(posedge clk) begin
    if (rd_d) chk(sw_rdata, reg_q.pop_front());
    rd_d <= sw_rd;
    if (cam_out.valid) begin
      ce = (cam_q.size() > 0) ? cam_q.pop_front() : '1;
      chk(32'({cam_out.flag, cam_out.enc, cam_out.lines} & ce[43:22]),
          32'(ce[21:0] & ce[43:22]));
    end
    if (done) chk(32'(pick), 32'(pick_q.pop_front()));
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      results();
    end
  end

  initial begin
    k = $urandom(32'h19939f7d);
    for (int i = 0; i < 32; i++) begin
      tv[i] = '0;
      tc[i] = '1;
    end
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    sw_r(emc_pkg::REG_CFG, emc_pkg::CFG_RST);
    sw_w(emc_pkg::REG_CFG, 32'h0000_0002);
    sw_r(emc_pkg::REG_CFG, 32'h0000_0002);
    sw_r(4'h8, 32'h0000_0000);
    for (int i = 0; i < 32; i++) cam_req(1'b1, 1'b0, 5'(i), $urandom(), '0);
    cam_req(1'b1, 1'b0, 5'd21, tv[12], '0);
    cam_req(1'b1, 1'b1, 5'd5, tv[5], 32'hffff_ff00);
    for (int m = 0; m < 6; m++) begin
      sw_w(emc_pkg::REG_CFG, 32'h2 | 32'(m / 2) << 2 | 32'(m % 2) << 4);
      arm <= (m == 2);
      look(tv[12], m / 2, m[0]);
      // Status: flag set, not busy, lowest hit 12 in every mode
      sw_r(emc_pkg::REG_STAT, 32'h0000_0c01);
      look(tv[5] ^ 32'h0000_005a, m / 2, m[0]);
      look(tv[3] ^ 32'h8000_0000, m / 2, m[0]);
      look(~tv[7], m / 2, m[0]);
      look(tv[30], m / 2, m[0]);
    end
    sw_w(emc_pkg::REG_CFG, 32'h0000_07e0);
    k = $urandom();
    ram(1'b0, k[7:0], k[23:8], k[23:8], k[23:8]);
    ram(1'b1, k[7:0], ~k[23:8], k[23:8], k[23:8]);
    sw_w(emc_pkg::REG_CFG, 32'h0000_07e3);
    ram(1'b0, k[7:0], k[15:0], k[23:8], k[23:8]);
    // Single port: A owns the lower half, B reads the upper half untouched by A
    sw_w(emc_pkg::REG_CFG, 32'h0000_07e1);
    ram(1'b0, k[7:0], ~k[23:8], k[7] ? k[23:8] : 16'h0000, ~k[23:8]);
    glb_clr <= 1'b1;
    @(posedge clk);
    glb_clr <= 1'b0;
    @(negedge clk);
    chk(32'(cam_out), 32'h0000_0000);
    chk(32'(b_dout), 32'h0000_0000);
    chk(32'(a_dout), 32'h0000_0000);
    repeat (3) @(posedge clk);
    failures += cam_q.size() + reg_q.size() + pick_q.size();
    results();
  end
endmodule
